// ### verilog/sync_serial_pkg.sv
package sync_serial_pkg;

  // bus geometry
  localparam int         ADDR_W = 8;
  localparam int         DATA_W = 32;

  // register byte addresses, one aligned word each
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_UPPER   = 8'h08;
  localparam logic [7:0] OFF_LOWER   = 8'h0C;
  localparam logic [7:0] OFF_DONE    = 8'h10;

  // status/control field positions and values
  localparam int         ST_FIXED     = 7;
  localparam int         ST_OUT_LEVEL = 6;
  localparam int         ST_OVERRUN   = 5;
  localparam int         ST_TRAIL     = 1;
  localparam int         ST_START     = 0;
  localparam logic [7:0] STATUS_RESET = 8'h9C;
  localparam logic [2:0] ST_RESERVED  = 3'h7;

  // mode/clock control field positions
  localparam int         CT_MODE_HI   = 7;
  localparam int         CT_MODE_LO   = 6;
  localparam int         CT_TRAIL_EN  = 5;
  localparam int         CT_LATCH     = 4;
  localparam int         CT_CLK_SRC   = 3;
  localparam int         CT_PRESC_HI  = 2;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // word lengths in bits
  localparam logic [4:0] BITS_8  = 5'h08;
  localparam logic [4:0] BITS_16 = 5'h10;

  // half serial-clock periods in system clocks, index = prescaler select
  localparam int         DIV_W = 10;
  localparam logic [7:0][DIV_W-1:0] HALF_TABLE = {10'h001, 10'h002, 10'h004, 10'h008,
                                                  10'h010, 10'h020, 10'h080, 10'h200};

  // trailer length in serial-clock periods
  localparam int         TRAILER_PERIODS = 2;

  typedef enum logic [1:0]
  {
    MODE_8BIT  = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_CONT  = 2'b10,
    MODE_RSVD  = 2'b11
  } mode_e;

  typedef enum logic [1:0]
  {
    PH_IDLE  = 2'b00,
    PH_SHIFT = 2'b01,
    PH_TRAIL = 2'b10
  } phase_e;

  typedef struct packed
  {
    logic [DIV_W-1:0] count;
    logic             level;
  } div_s;

  // serial pin group
  typedef struct packed
  {
    logic data_out;
    logic clock_out;
    logic clock_oe_n;
  } pins_s;

endpackage

// ### verilog/sclk_divider.sv
`timescale 1ns/1ps
// internal serial clock: idles high, first event is a falling edge
module sclk_divider
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            level,
  output logic            rise,
  output logic            fall
);

  sync_serial_pkg::div_s st;
  sync_serial_pkg::div_s next_st;
  logic [sync_serial_pkg::DIV_W-1:0] half;
  logic                              tick;

  // half period lookup and edge strobes
  assign half  = sync_serial_pkg::HALF_TABLE[sel];
  assign tick  = ce && run && (st.count == half - 10'h001);
  assign fall  = tick && st.level;
  assign rise  = tick && !st.level;
  assign level = st.level;

  // stopping parks the clock high so the next start begins cleanly
  always_comb
  begin
    next_st = st;
    if (ce)
    begin
      if (!run)
      begin
        next_st.count = '0;
        next_st.level = 1'b1;
      end
      else if (tick)
      begin
        next_st.count = '0;
        next_st.level = !st.level;
      end
      else
      begin
        next_st.count = st.count + 10'h001;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st.count <= '0;
      st.level <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

// ### verilog/sync_serial_unit.sv
// Functional notes
// - status register resets to 9C hex
// - status bit 7 reads one, ignores writes
// - status bits 4..2 ignore writes
// - out level bit writes pin when idle
// - out level bit reads actual pin level
// - pin keeps last shifted bit after transfer, high after a trailer
// - transfer start overrides out level, trailer settings
// - external clock after completion sets overrun
// - overrun cleared by zero after read one
// - trailer flag high only while trailer sends
// - writing start one begins transfer, except in continuous mode
// - start flag stays high until completion; a control write clears it early
// - 8-bit: lower shifts out LSB, in MSB
// - 16-bit: serial input enters through upper
// - 16-bit: lower fed from upper register
// - data registers have no reset value
// - four mode codes: 8, 16, continuous, reserved
// - clock source bit selects pin direction
// - trailer enable appends trailer after data
// - completion sets transfer done flag
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module sync_serial_unit
#(
  parameter int TRAILER_PERIODS = sync_serial_pkg::TRAILER_PERIODS
)
(
  input  wire logic                                clock,
  input  wire logic                                reset,
  input  wire logic                                ce,
  input  wire logic [sync_serial_pkg::ADDR_W-1:0]  address,
  input  wire logic                                read,
  input  wire logic                                write,
  input  wire logic [sync_serial_pkg::DATA_W-1:0]  writedata,
  input  wire logic [3:0]                          byteenable,
  output logic      [sync_serial_pkg::DATA_W-1:0]  readdata,
  output logic                                     waitrequest,
  input  wire logic                                serial_in_pin,
  input  wire logic                                serial_clock_in,
  output sync_serial_pkg::pins_s                   serial_pins,
  output logic                                     transfer_done_irq_flag
);

  // trailer counter is two bits wide
  if (TRAILER_PERIODS < 1 || TRAILER_PERIODS > 3)
  begin : g_check
    $error("TRAILER_PERIODS must be 1 to 3");
  end

  typedef struct packed
  {
    logic [7:0]              ctrl;
    logic                    ack;
    logic [31:0]             rdata;
    logic                    out_level;
    logic                    overrun;
    logic                    overrun_seen;
    logic                    busy;
    logic                    done;
    logic [7:0]              upper;
    logic [7:0]              lower;
    sync_serial_pkg::phase_e phase;
    logic [4:0]              bit_count;
    logic [1:0]              trail_count;
    logic                    ext_prev;
  } unit_s;

  unit_s                   st;
  unit_s                   next_st;
  sync_serial_pkg::mode_e  mode;
  logic                    ext_sel;
  logic                    ext_rise;
  logic                    ext_fall;
  logic                    div_level;
  logic                    div_rise;
  logic                    div_fall;
  logic                    div_run;
  logic                    sck_rise;
  logic                    sck_fall;
  logic                    take;
  logic                    acc_w;
  logic                    acc_r;
  logic                    finish;
  logic                    ovr_set;
  logic [4:0]              last_bit;
  logic [7:0]              status_view;
  logic [31:0]             rd_mux;

  // control decode
  assign mode    = sync_serial_pkg::mode_e'(st.ctrl[sync_serial_pkg::CT_MODE_HI:sync_serial_pkg::CT_MODE_LO]);
  assign ext_sel = st.ctrl[sync_serial_pkg::CT_CLK_SRC];
  assign last_bit = (mode == sync_serial_pkg::MODE_16BIT) ? sync_serial_pkg::BITS_16 - 5'h01
                                                          : sync_serial_pkg::BITS_8 - 5'h01;

  // pins are synchronous, a plain previous-value compare finds the edges
  assign ext_rise = serial_clock_in && !st.ext_prev;
  assign ext_fall = !serial_clock_in && st.ext_prev;

  // prescaler runs, with the internal clock selected, for a transfer or in continuous clock mode
  assign div_run  = !ext_sel && (st.busy || mode == sync_serial_pkg::MODE_CONT);
  assign sck_rise = ce && (ext_sel ? ext_rise : div_rise);
  assign sck_fall = ce && (ext_sel ? ext_fall : div_fall);

  sclk_divider u_div
  (
    .clock (clock),
    .reset (reset),
    .ce    (ce),
    .run   (div_run),
    .sel   (st.ctrl[sync_serial_pkg::CT_PRESC_HI:0]),
    .level (div_level),
    .rise  (div_rise),
    .fall  (div_fall)
  );

  // bus handshake: one wait cycle, then the access completes
  assign take        = (read || write) && !st.ack;
  assign waitrequest = (read || write) && !st.ack;
  assign acc_w       = ce && st.ack && write && byteenable[0];
  assign acc_r       = ce && st.ack && read;

  // status view: fixed and reserved bits read one, level is the pin itself
  assign status_view = {1'b1,
                        st.out_level,
                        st.overrun,
                        sync_serial_pkg::ST_RESERVED,
                        st.phase == sync_serial_pkg::PH_TRAIL,
                        st.busy};

  // read mux, unmapped addresses read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (address == sync_serial_pkg::OFF_CONTROL)
      rd_mux[7:0] = st.ctrl;
    else if (address == sync_serial_pkg::OFF_STATUS)
      rd_mux[7:0] = status_view;
    else if (address == sync_serial_pkg::OFF_UPPER)
      rd_mux[7:0] = st.upper;
    else if (address == sync_serial_pkg::OFF_LOWER)
      rd_mux[7:0] = st.lower;
    else if (address == sync_serial_pkg::OFF_DONE)
      rd_mux[0] = st.done;
  end

  // serial engine first, bus writes after so software wins over data
  always_comb
  begin
    next_st = st;
    finish  = 1'b0;
    ovr_set = 1'b0;
    if (ce)
    begin
      next_st.ack      = take;
      next_st.ext_prev = serial_clock_in;
      if (take && read)
        next_st.rdata = rd_mux;
      case (st.phase)
        sync_serial_pkg::PH_IDLE:
        begin
          if (ext_sel && ext_rise)
          begin
            ovr_set         = 1'b1;
            next_st.overrun = 1'b1;
          end
        end
        sync_serial_pkg::PH_SHIFT:
        begin
          if (sck_fall)
            next_st.out_level = st.lower[0];
          if (sck_rise)
          begin
            if (mode == sync_serial_pkg::MODE_16BIT)
            begin
              next_st.upper = {serial_in_pin, st.upper[7:1]};
              next_st.lower = {st.upper[0], st.lower[7:1]};
            end
            else
            begin
              next_st.lower = {serial_in_pin, st.lower[7:1]};
            end
            next_st.bit_count = st.bit_count + 5'h01;
            if (st.bit_count == last_bit)
            begin
              if (st.ctrl[sync_serial_pkg::CT_TRAIL_EN])
              begin
                next_st.phase       = sync_serial_pkg::PH_TRAIL;
                next_st.trail_count = 2'h0;
              end
              else
              begin
                next_st.phase = sync_serial_pkg::PH_IDLE;
                next_st.busy  = 1'b0;
                finish        = 1'b1;
              end
            end
          end
        end
        sync_serial_pkg::PH_TRAIL:
        begin
          // hold tail stays high, latch tail pulls low once
          if (sck_fall)
            next_st.out_level = !st.ctrl[sync_serial_pkg::CT_LATCH];
          if (sck_rise)
          begin
            next_st.trail_count = st.trail_count + 2'h1;
            if (st.trail_count == 2'(TRAILER_PERIODS - 1))
            begin
              next_st.phase     = sync_serial_pkg::PH_IDLE;
              next_st.busy      = 1'b0;
              next_st.out_level = 1'b1;
              finish            = 1'b1;
            end
          end
        end
        default:
        begin
          next_st.phase = sync_serial_pkg::PH_IDLE;
        end
      endcase
      if (finish)
        next_st.done = 1'b1;
      // arm the overrun clear only once software has seen it set
      if (acc_r && address == sync_serial_pkg::OFF_STATUS && st.rdata[sync_serial_pkg::ST_OVERRUN])
        next_st.overrun_seen = 1'b1;
      if (acc_w)
      begin
        if (address == sync_serial_pkg::OFF_CONTROL)
        begin
          // a mode write aborts any transfer in flight
          next_st.ctrl  = writedata[7:0];
          next_st.phase = sync_serial_pkg::PH_IDLE;
          next_st.busy  = 1'b0;
        end
        else if (address == sync_serial_pkg::OFF_STATUS)
        begin
          // bits 7 and 4..2 have no storage, so writes there vanish
          if (!st.busy)
          begin
            next_st.out_level = writedata[sync_serial_pkg::ST_OUT_LEVEL];
            if (writedata[sync_serial_pkg::ST_START] && mode != sync_serial_pkg::MODE_CONT)
            begin
              next_st.busy      = 1'b1;
              next_st.phase     = sync_serial_pkg::PH_SHIFT;
              next_st.bit_count = 5'h00;
            end
          end
          // set wins over clear, writing one leaves the flag alone
          if (!writedata[sync_serial_pkg::ST_OVERRUN] && st.overrun_seen && !ovr_set)
          begin
            next_st.overrun      = 1'b0;
            next_st.overrun_seen = 1'b0;
          end
        end
        else if (address == sync_serial_pkg::OFF_UPPER)
          next_st.upper = writedata[7:0];
        else if (address == sync_serial_pkg::OFF_LOWER)
          next_st.lower = writedata[7:0];
        else if (address == sync_serial_pkg::OFF_DONE)
        begin
          if (!writedata[0] && !finish)
            next_st.done = 1'b0;
        end
      end
    end
  end

  // data registers deliberately left out of reset
  always_ff @(posedge clock)
  begin
    st <= next_st;
    if (reset)
    begin
      st.ctrl         <= sync_serial_pkg::CONTROL_RESET;
      st.ack          <= 1'b0;
      st.rdata        <= 32'h0000_0000;
      st.out_level    <= sync_serial_pkg::STATUS_RESET[sync_serial_pkg::ST_OUT_LEVEL];
      st.overrun      <= sync_serial_pkg::STATUS_RESET[sync_serial_pkg::ST_OVERRUN];
      st.overrun_seen <= 1'b0;
      st.busy         <= sync_serial_pkg::STATUS_RESET[sync_serial_pkg::ST_START];
      st.done         <= 1'b0;
      st.phase        <= sync_serial_pkg::PH_IDLE;
      st.bit_count    <= 5'h00;
      st.trail_count  <= 2'h0;
      st.ext_prev     <= 1'b1;                                 // pin idles high
    end
  end

  // pin drive, clock pin released when the partner clocks
  assign readdata               = st.rdata;
  assign serial_pins.data_out   = st.out_level;
  assign serial_pins.clock_out  = div_level;
  assign serial_pins.clock_oe_n = ext_sel;
  assign transfer_done_irq_flag = st.done;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_fixed_bit;
    ce && read && !st.ack && address == sync_serial_pkg::OFF_STATUS |=> readdata[7];
  endproperty
  a_fixed_bit: assert property (p_fixed_bit) else $error("status bit 7 read as zero");

  property p_reserved_one;
    ce && read && !st.ack && address == sync_serial_pkg::OFF_STATUS |=> readdata[4:2] == 3'h7;
  endproperty
  a_reserved_one: assert property (p_reserved_one) else $error("reserved bits not one");

  property p_start_busy;
    acc_w && address == sync_serial_pkg::OFF_STATUS && writedata[0] && !st.busy
      && mode != sync_serial_pkg::MODE_CONT |=> st.busy && st.phase == sync_serial_pkg::PH_SHIFT;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not set busy");

  property p_overrun_hold;
    st.overrun && acc_w && address == sync_serial_pkg::OFF_STATUS && writedata[5] |=> st.overrun;
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("writing one cleared overrun");

  property p_overrun_set;
    ce && ext_sel && ext_rise && st.phase == sync_serial_pkg::PH_IDLE |=> st.overrun;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not set");

  property p_level_write;
    acc_w && address == sync_serial_pkg::OFF_STATUS && !st.busy
      |=> serial_pins.data_out == $past(writedata[6]);
  endproperty
  a_level_write: assert property (p_level_write) else $error("out level not on pin");

  property p_shift8;
    sck_rise && st.phase == sync_serial_pkg::PH_SHIFT && mode == sync_serial_pkg::MODE_8BIT
      && !acc_w |=> st.lower[7] == $past(serial_in_pin);
  endproperty
  a_shift8: assert property (p_shift8) else $error("8-bit input not at MSB");

  property p_shift16;
    sck_rise && st.phase == sync_serial_pkg::PH_SHIFT && mode == sync_serial_pkg::MODE_16BIT
      && !acc_w |=> st.lower[7] == $past(st.upper[0]) && st.upper[7] == $past(serial_in_pin);
  endproperty
  a_shift16: assert property (p_shift16) else $error("16-bit chain broken");

  property p_done;
    finish |=> transfer_done_irq_flag && !st.busy;
  endproperty
  a_done: assert property (p_done) else $error("done flag missing");

  property p_trail_flag;
    status_view[1] |-> st.busy && st.ctrl[sync_serial_pkg::CT_TRAIL_EN];
  endproperty
  a_trail_flag: assert property (p_trail_flag) else $error("trailer flag outside a trailer");

  c_finish:  cover property (finish);
  c_trailer: cover property (st.phase == sync_serial_pkg::PH_TRAIL ##1 finish);
  c_overrun: cover property (ovr_set);

endmodule

// ### tb/serial_partner.sv
`timescale 1ns/1ps
// far-side serial device: sends a word on our input line, captures our output line
module serial_partner
#(
  parameter int HALF = 4
)
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        line_clk,
  input  wire logic        sdo,
  input  wire logic        load,
  input  wire logic [15:0] load_word,
  input  wire logic        go,
  input  wire logic [4:0]  pulses,
  output logic             sdi,
  output logic             ext_clk,
  output logic      [15:0] rx_word
);
  logic        prev;
  logic [15:0] tx;
  logic [1:0]  dly;
  int          left;
  int          ph;
  int          got;

  // data moves two cycles after a seen rise, clear of the sampling point
  always @(posedge clock)
  begin
    if (reset)
    begin
      prev <= 1'b1;
      ext_clk <= 1'b1;
      left <= 0;
      ph <= 0;
      dly <= 2'd0;
      sdi <= 1'b0;
      got <= 0;
    end
    else
    begin
      prev <= line_clk;
      if (dly != 2'd0)
        dly <= dly - 2'd1;
      if (load)
      begin
        tx <= load_word >> 1;
        sdi <= load_word[0];
        got <= 0;
        rx_word <= 16'h0000; // short words leave zeros below the captured byte
      end
      if (dly == 2'd1)
      begin
        sdi <= tx[0];
        tx <= {~tx[0], tx[15:1]}; // inverse refill: a stale line never looks valid
      end
      if (line_clk && !prev && got < int'(pulses))
      begin
        rx_word <= {sdo, rx_word[15:1]}; // lsb first capture
        dly <= 2'd2;
        got <= got + 1;
      end
      // clock stands high between bursts; a burst after the word provokes overrun
      if (go)
      begin
        left <= int'(pulses);
        ph <= 0;
      end
      else if (left != 0)
      begin
        ext_clk <= (ph >= HALF);
        ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
        if (ph == 2 * HALF - 1)
          left <= left - 1;
      end
      else
        ext_clk <= 1'b1;
    end
  end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                   clock;
  logic                   reset;
  logic                   ce;
  logic [7:0]             address;
  logic                   read;
  logic                   write;
  logic [31:0]            writedata;
  logic [3:0]             byteenable;
  logic [31:0]            readdata;
  logic                   waitrequest;
  logic                   sdi;
  logic                   ext_clk;
  logic                   line_clk;
  logic                   done_flag;
  logic                   load;
  logic                   go;
  logic [4:0]             pulses;
  logic [15:0]            load_word;
  logic [15:0]            rx_word;
  logic [31:0]            q;
  sync_serial_pkg::pins_s pins;
  int                     errors;
  int                     num_checks;
  int                     m_out;
  int                     m_ovr;
  logic [7:0]             ctl_table [0:4] = '{8'h05, 8'h45, 8'hC5, 8'h25, 8'h65};

  // wire level of the clock pin from both parties
  assign line_clk = pins.clock_oe_n ? ext_clk : pins.clock_out;

  sync_serial_unit #(.TRAILER_PERIODS(2)) dut (.clock(clock), .reset(reset), .ce(ce), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .serial_in_pin(sdi), .serial_clock_in(line_clk), .serial_pins(pins),
    .transfer_done_irq_flag(done_flag));

  serial_partner #(.HALF(4)) partner (.clock(clock), .reset(reset), .line_clk(line_clk),
    .sdo(pins.data_out), .load(load), .load_word(load_word), .go(go), .pulses(pulses), .sdi(sdi),
    .ext_clk(ext_clk), .rx_word(rx_word));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string what);
    chk_reg({15'h0, got}, {15'h0, exp}, what);
  endtask

  // expected status from the model's pin level and overrun flag
  function automatic logic [15:0] st(input logic busy);
    return {8'h00, 1'b1, m_out[0], m_ovr[0], 3'b111, 1'b0, busy};
  endfunction

  // one bus cycle; holds until waitrequest is sampled low, then idles one edge
  task automatic bus(input logic wr, input logic [3:0] be, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= wr;
    read <= !wr;
    do
      @(posedge clock);
    while (waitrequest !== 1'b0 && ++n < 40);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 40)
      chk_pin(1'b1, 1'b0, "bus hang");
    @(posedge clock);
  endtask

  task automatic wait_idle(output int tr);
    int k;
    tr = 0;
    for (k = 0; k < 300; k++)
    begin
      bus(1'b0, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h00);
      if (k == 0)
        chk_pin(q[0], 1'b1, "busy at start");
      chk_reg({12'h0, q[7], q[4:2]}, 16'h000F, "fixed bits");
      tr += (q[1] === 1'b1);
      if (q[0] === 1'b0)
        break;
    end
    if (k == 300)
      chk_pin(1'b1, 1'b0, "never idle");
  endtask

  task automatic xfer(input logic [7:0] ctl, input logic [15:0] tx, input logic [15:0] pw, input logic ext);
    int          k;
    int          nb;
    int          tr;
    logic [15:0] dev;
    logic [15:0] far;
    sync_serial_pkg::pins_s snap;
    nb = (ctl[7:6] == 2'b01) ? 16 : 8;
    dev = 16'h0;
    far = 16'h0;
    // reference model: both ends send lsb first, receivers fill from the msb
    for (k = 0; k < nb; k++)
    begin
      dev = (dev >> 1) | (16'(pw[k]) << (nb - 1));
      far = {tx[k], far[15:1]};
    end
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_CONTROL, ctl);
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_UPPER, tx[15:8]);
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_LOWER, tx[7:0]);
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_DONE, 8'h00);
    load_word <= pw;
    pulses <= 5'(nb);
    load <= 1'b1;
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h41); // level set high, then data takes over
    load <= 1'b0;
    go <= ext;
    @(posedge clock);
    go <= 1'b0;
    // clock enable low just after start, before the first bit: pins must freeze and the word must still arrive intact
    if (!ext)
    begin
      ce <= 1'b0;
      @(posedge clock);
      snap = pins;
      repeat (6) @(posedge clock);
      chk_reg(16'(pins), 16'(snap), "ce freeze");
      ce <= 1'b1;
    end
    wait_idle(tr); // status left unwritten while busy
    chk_pin(tr != 0, ctl[5], "trailer flag");
    m_out = ctl[5] ? 1 : int'(tx[nb - 1]);
    chk_pin(pins.data_out, m_out[0], "held level");
    chk_pin(done_flag, 1'b1, "done flag");
    bus(1'b0, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h00);
    chk_reg(q[15:0], st(1'b0), "status idle");
    bus(1'b0, 4'hF, sync_serial_pkg::OFF_LOWER, 8'h00); // data read only once idle
    chk_reg(q[15:0], {8'h0, dev[7:0]}, "lower rx");
    bus(1'b0, 4'hF, sync_serial_pkg::OFF_UPPER, 8'h00);
    if (nb == 16)
      chk_reg(q[15:0], {8'h0, dev[15:8]}, "upper rx");
    chk_reg(rx_word, far, "far end rx");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // run limit well above the longest expected sequence
  initial
  begin
    repeat (30000) @(posedge clock);
    chk_pin(1'b1, 1'b0, "watchdog");
    finish_test;
  end

  initial
  begin
    int i;
    void'($urandom(32'hd2b1));
    ce = 1'b1;
    read = 1'b0;
    write = 1'b0;
    load = 1'b0;
    go = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'h0;
    pulses = 5'h00;
    load_word = 16'h0;
    m_ovr = 0;
    reset = 1'b1;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    bus(1'b0, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h00);
    chk_reg(q[15:0], 16'h009C, "status reset");
    chk_pin(pins.clock_oe_n, 1'b0, "clock driven");
    $display("test reset done");
    // bit 7, reserved bits, overrun and trailer flag ignore this write
    m_out = 1;
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h62);
    bus(1'b1, 4'h0, sync_serial_pkg::OFF_STATUS, 8'h00);
    bus(1'b1, 4'hF, 8'h14, 8'hFF);
    bus(1'b0, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h00);
    chk_reg(q[15:0], st(1'b0), "status write");
    chk_pin(pins.data_out, 1'b1, "level high");
    bus(1'b0, 4'hF, 8'h14, 8'h00);
    chk_reg(q[15:0], 16'h0000, "unmapped");
    m_out = 0;
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h00);
    bus(1'b0, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h00);
    chk_reg(q[15:0], st(1'b0), "start zero");
    chk_pin(pins.data_out, 1'b0, "level low");
    $display("test status done");
    for (i = 0; i < 10; i++)
      xfer(ctl_table[i % 5], 16'($urandom), 16'($urandom), 1'b0);
    $display("test internal transfers done");
    m_out = 0;
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_CONTROL, 8'h85);
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h01);
    bus(1'b0, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h00);
    chk_reg(q[15:0], st(1'b0), "continuous start");
    for (i = 0; i < 20 && pins.clock_out; i++)
      @(posedge clock);
    chk_pin(pins.clock_out, 1'b0, "continuous clock");
    // park the internal clock high before handing the pin to the partner
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_CONTROL, 8'h05);
    $display("test continuous done");
    xfer(8'h08, 16'($urandom), 16'($urandom), 1'b1);
    chk_pin(pins.clock_oe_n, 1'b1, "clock input");
    pulses <= 5'd1;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (14) @(posedge clock);
    m_out = 0;
    m_ovr = 1;
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h00);
    bus(1'b0, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h00);
    chk_reg(q[15:0], st(1'b0), "overrun set");
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h20);
    bus(1'b0, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h00);
    chk_reg(q[15:0], st(1'b0), "overrun write one");
    bus(1'b1, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h00);
    m_ovr = 0;
    bus(1'b0, 4'hF, sync_serial_pkg::OFF_STATUS, 8'h00);
    chk_reg(q[15:0], st(1'b0), "overrun cleared");
    $display("test external clock done");
    finish_test;
  end
endmodule
